// >>> rtl/watchdog_timer.sv
/*
  Watchdog timer: 9-bit signed down counter, NMI and system reset
  request, freeze control and APB register slave with interrupt.
  Assumes the system reset controller feeds its reset back on rst_in
  and the debug halt status is a level from another clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1 - Count down by one on every 10.24 ms tick unless frozen, with an 8-bit magnitude.
// RULE2 - Load 255 into the counter on reset, including watchdog resets.
// RULE3 - Ignore counter writes whose write-block bit is set.
// RULE4 - Continue below zero by setting sign bit 8, down to 1F0.
// RULE5 - With reset-select low, raise the NMI when the counter reaches zero.
// RULE6 - With reset-select low, request reset at or below minus sixteen.
// RULE7 - Software must reload above minus sixteen within about 16 ticks of the NMI.
// RULE8 - With reset-select high, request reset at or below zero with no NMI.
// RULE9 - Drive the reset request to the system reset logic.
// RULE10 - Stop counting whenever the processor is halted in debug.
// RULE11 - Freeze on a freeze-set write only while reset-select is low.
// RULE12 - End a software freeze on a freeze-clear write.
// RULE13 - Software can only set reset-select; only reset clears it.
// RULE14 - While frozen hold the count and raise no new events.
module watchdog_timer #(
  parameter int TICK_DIV = wd_pkg::TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic debug_halt_ctrl_in,
  output logic nmi_out,
  output logic wd_system_reset_req_out,
  output logic irq_out
);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_COUNT = 2'b00,
    ST_NMI_SENT = 2'b01,
    ST_RESET = 2'b11
  } wd_state_t;
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (TICK_DIV < 2) begin : g_bad_tick_div
    $error("watchdog_timer: TICK_DIV must be at least 2");
  end
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    return (addr == off);
  endfunction
  function automatic logic at_or_below(input logic [8:0] cnt, input logic [8:0] lim);
    return ($signed(cnt) <= $signed(lim));
  endfunction
  // ----------------------------------------
  // Debug halt synchroniser
  // ----------------------------------------
  logic halt_meta_r;
  logic halt_sync_r;
  logic tick;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      halt_meta_r <= 1'b0;
      halt_sync_r <= 1'b0;
    end else begin
      halt_meta_r <= debug_halt_ctrl_in;
      halt_sync_r <= halt_meta_r;
    end
  end
  // ----------------------------------------
  // Tick divider
  // ----------------------------------------
  wd_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tick_out(tick)
  );
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire access = psel_in && penable_in;
  wire wr = access && pwrite_in;
  wire setup_phase = psel_in && !penable_in;
  wire rd_setup = setup_phase && !pwrite_in;
  wire sel_count = addr_hit(paddr_in, wd_pkg::OFF_COUNT);
  wire sel_ctrl = addr_hit(paddr_in, wd_pkg::OFF_CTRL);
  wire sel_fset = addr_hit(paddr_in, wd_pkg::OFF_FRZ_SET);
  wire sel_fclr = addr_hit(paddr_in, wd_pkg::OFF_FRZ_CLR);
  wire sel_stat = addr_hit(paddr_in, wd_pkg::OFF_STATUS);
  wire sel_mask = addr_hit(paddr_in, wd_pkg::OFF_MASK);
  wire mapped = sel_count | sel_ctrl | sel_fset | sel_fclr | sel_stat | sel_mask;
  wire unmapped = !mapped || (paddr_in[1:0] != 2'b00);
  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic [8:0] count_r;
  logic [8:0] count_nxt;
  logic rst_sel_r;
  logic rst_sel_nxt;
  logic sw_freeze_r;
  logic sw_freeze_nxt;
  logic [wd_pkg::NUM_EVENTS-1:0] status_r;
  logic [wd_pkg::NUM_EVENTS-1:0] status_nxt;
  logic [wd_pkg::NUM_EVENTS-1:0] mask_r;
  logic [wd_pkg::NUM_EVENTS-1:0] mask_nxt;
  wd_state_t state_r;
  wd_state_t state_nxt;
  // ----------------------------------------
  // Counter and freeze
  // ----------------------------------------
  wire count_wr = wr && sel_count && !pwdata_in[wd_pkg::BIT_WRITE_BLOCK]; // RULE3
  wire eff_sw_freeze = sw_freeze_r && !rst_sel_r; // RULE11
  wire frozen = halt_sync_r || eff_sw_freeze; // RULE10 RULE14
  wire step = tick && !frozen; // RULE1 RULE14
  wire [8:0] count_dec = count_r - wd_pkg::CNT_ONE; // RULE4
  wire at_floor = at_or_below(count_r, wd_pkg::CNT_MINUS16); // RULE4
  assign count_nxt = count_wr ? pwdata_in[8:0] :
                     (step && !at_floor) ? count_dec : count_r; // RULE1 RULE4
  assign rst_sel_nxt = rst_sel_r | (wr && sel_ctrl && pwdata_in[wd_pkg::BIT_RST_SEL]); // RULE13
  wire fset = wr && sel_fset && pwdata_in[wd_pkg::BIT_FREEZE] && !rst_sel_r; // RULE11
  wire fclr = wr && sel_fclr && pwdata_in[wd_pkg::BIT_FREEZE]; // RULE12
  assign sw_freeze_nxt = fset ? 1'b1 : (fclr ? 1'b0 : sw_freeze_r);
  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  wire le_zero = at_or_below(count_r, wd_pkg::CNT_ZERO);
  wire le_m16 = at_or_below(count_r, wd_pkg::CNT_MINUS16);
  wire hit_zero = (count_r == wd_pkg::CNT_ZERO);
  wire nmi_ev = !rst_sel_r && hit_zero && !frozen && (state_r == ST_COUNT); // RULE5 RULE14
  wire rst_ev = !frozen && (rst_sel_r ? le_zero : le_m16); // RULE6 RULE8 RULE14
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_COUNT: begin
        if (rst_ev) begin
          state_nxt = ST_RESET;
        end else if (nmi_ev) begin
          state_nxt = ST_NMI_SENT;
        end
      end
      ST_NMI_SENT: begin
        if (rst_ev) begin
          state_nxt = ST_RESET;
        end else if (!le_zero) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_RESET: begin
        state_nxt = ST_RESET;
      end
      default: begin
        state_nxt = ST_COUNT;
      end
    endcase
  end
  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic [wd_pkg::NUM_EVENTS-1:0] ev_set;
  logic [wd_pkg::NUM_EVENTS-1:0] ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[wd_pkg::ST_NMI] = nmi_ev;
    ev_set[wd_pkg::ST_RST] = rst_ev && (state_r != ST_RESET);
  end
  assign ev_clr = (wr && sel_stat) ? pwdata_in[wd_pkg::NUM_EVENTS-1:0] : '0;
  assign status_nxt = ev_set | (status_r & ~ev_clr);
  assign mask_nxt = (wr && sel_mask) ? pwdata_in[wd_pkg::NUM_EVENTS-1:0] : mask_r;
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    if (sel_count) begin
      rdata[8:0] = count_r;
    end else if (sel_ctrl) begin
      rdata[wd_pkg::BIT_RST_SEL] = rst_sel_r;
      rdata[wd_pkg::BIT_FROZEN] = frozen;
    end else if (sel_stat) begin
      rdata[wd_pkg::NUM_EVENTS-1:0] = status_r;
    end else if (sel_mask) begin
      rdata[wd_pkg::NUM_EVENTS-1:0] = mask_r;
    end else if (sel_fset || sel_fclr) begin
      rdata[wd_pkg::BIT_FREEZE] = sw_freeze_r;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count_r <= wd_pkg::CNT_RESET; // RULE2
    end else begin
      count_r <= count_nxt;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= ST_COUNT;
    end else begin
      state_r <= state_nxt;
    end
  end
  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rst_sel_r <= 1'b0; // RULE13
    end else begin
      rst_sel_r <= rst_sel_nxt;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sw_freeze_r <= 1'b0;
    end else begin
      sw_freeze_r <= sw_freeze_nxt;
    end
  end
  // ----------------------------------------
  // Status and mask
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end
  // ----------------------------------------
  // Output next values
  // ----------------------------------------
  wire nmi_nxt = (state_nxt == ST_NMI_SENT); // RULE5
  wire req_nxt = (state_nxt == ST_RESET); // RULE9
  wire irq_nxt = |(status_nxt & mask_nxt);
  wire pready_nxt = setup_phase;
  wire pslverr_nxt = setup_phase && unmapped;
  wire [31:0] prdata_nxt = rd_setup ? rdata : '0;
  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      nmi_out <= 1'b0;
    end else begin
      nmi_out <= nmi_nxt; // RULE5
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wd_system_reset_req_out <= 1'b0;
    end else begin
      wd_system_reset_req_out <= req_nxt; // RULE9
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_nxt;
    end
  end
  // ----------------------------------------
  // APB response
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out <= prdata_nxt;
      pready_out <= pready_nxt;
      pslverr_out <= pslverr_nxt;
    end
  end
endmodule // watchdog_timer
`default_nettype wire

// >>> rtl/wd_pkg.sv
/*
  Constants shared by the watchdog design: register offsets, field
  positions, reset values and tick timing.
  Assumes a 100 MHz core clock and 32-bit APB access.
*/
package wd_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_FRZ_SET = 8'h08;
  localparam logic [7:0] OFF_FRZ_CLR = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_WRITE_BLOCK = 9;
  localparam int BIT_RST_SEL = 0;
  localparam int BIT_FREEZE = 3;
  localparam int BIT_FROZEN = 1;
  localparam int ST_NMI = 0;
  localparam int ST_RST = 1;
  localparam int NUM_EVENTS = 2;
  // ----------------------------------------
  // Counter values
  // ----------------------------------------
  localparam logic [8:0] CNT_RESET = 9'h0ff;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_MINUS16 = 9'h1f0;
  localparam logic [8:0] CNT_ONE = 9'h001;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam real TICK_PERIOD_MS = 10.24;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
endpackage

// >>> rtl/wd_tick_gen.sv
/*
  Free running tick divider producing one-cycle pulses.
  Assumes a synchronous active high reset on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wd_tick_gen #(
  parameter int DIV = 1024000
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  if (DIV < 2) begin : g_bad_div
    $error("wd_tick_gen: DIV must be at least 2");
  end
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_last = (cnt_r == LAST);
  assign cnt_nxt = at_last ? '0 : cnt_r + W'(1);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= at_last;
    end
  end
endmodule // wd_tick_gen
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the watchdog timer over APB.
  Assumes a shortened tick divider and the reset model in the loop.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int DIV = 20;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic core_clk_in = 1'h0, por = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic halt = 1'h0, nmi_seen = 1'h0, rst, nmi, req, irq, pready, perr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int n_fail = 0, checks_done = 0, cyc = 0, n;
  row_t rows [16] = '{'{1'h1, wd_pkg::OFF_FRZ_SET, 32'h8, 32'h0, 1'h0},
    '{1'h0, wd_pkg::OFF_COUNT, 32'h0, 32'h0ff, 1'h0}, '{1'h0, wd_pkg::OFF_CTRL, 32'h0, 32'h2, 1'h0},
    '{1'h1, wd_pkg::OFF_COUNT, 32'h255, 32'h0, 1'h0}, '{1'h0, wd_pkg::OFF_COUNT, 32'h0, 32'h0ff, 1'h0},
    '{1'h1, wd_pkg::OFF_COUNT, 32'h0a0, 32'h0, 1'h0}, '{1'h0, wd_pkg::OFF_COUNT, 32'h0, 32'h0a0, 1'h0},
    '{1'h0, wd_pkg::OFF_STATUS, 32'h0, 32'h0, 1'h0}, '{1'h0, wd_pkg::OFF_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1}, '{1'h1, 8'h1a, 32'h5, 32'h0, 1'h1},
    '{1'h0, wd_pkg::OFF_FRZ_SET, 32'h0, 32'h8, 1'h0}, '{1'h1, wd_pkg::OFF_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, wd_pkg::OFF_CTRL, 32'h0, 32'h2, 1'h0}, '{1'h1, wd_pkg::OFF_FRZ_CLR, 32'h8, 32'h0, 1'h0},
    '{1'h0, wd_pkg::OFF_CTRL, 32'h0, 32'h0, 1'h0}};
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  wd_reset_ctrl u_rst (.por_in(por), .req_in(req), .rst_out(rst));
  watchdog_timer #(.TICK_DIV(DIV)) dut (.core_clk_in(core_clk_in), .rst_in(rst),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .debug_halt_ctrl_in(halt), .nmi_out(nmi), .wd_system_reset_req_out(req), .irq_out(irq));
  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (nmi === 1'h1) nmi_seen <= 1'h1;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'h1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'h1);
    q = prdata;
    e = perr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk_in);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge core_clk_in);
    por <= 1'h0;
    @(posedge core_clk_in);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("register rows done");
    bus(1'h1, wd_pkg::OFF_MASK, 32'h3);
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h2);
    n = 0;
    while (nmi !== 1'h1 && n < 100) begin @(posedge core_clk_in); n++; end
    chk({31'h0, n >= 19 && n <= 42}, 32'h1);
    bus(1'h0, wd_pkg::OFF_COUNT, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, wd_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    repeat (DIV) @(posedge core_clk_in);
    bus(1'h0, wd_pkg::OFF_COUNT, 32'h0);
    chk(q, 32'h1ff);
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h10);
    bus(1'h1, wd_pkg::OFF_STATUS, 32'h1);
    bus(1'h0, wd_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({30'h0, irq, nmi}, 32'h0);
    $display("nmi test done");
    bus(1'h1, wd_pkg::OFF_FRZ_SET, 32'h8);
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h40);
    repeat (100) @(posedge core_clk_in);
    bus(1'h0, wd_pkg::OFF_COUNT, 32'h0);
    chk(q, 32'h40);
    bus(1'h1, wd_pkg::OFF_FRZ_CLR, 32'h8);
    halt <= 1'h1;
    repeat (4) @(posedge core_clk_in);
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h0);
    repeat (100) @(posedge core_clk_in);
    bus(1'h0, wd_pkg::OFF_COUNT, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, nmi}, 32'h0);
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h0ff);
    halt <= 1'h0;
    $display("freeze test done");
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h1f1);
    n = 0;
    while (req !== 1'h1 && n < 100) begin @(posedge core_clk_in); n++; end
    chk({31'h0, req}, 32'h1);
    while (rst !== 1'h0 && n < 200) begin @(posedge core_clk_in); n++; end
    repeat (2) @(posedge core_clk_in);
    bus(1'h0, wd_pkg::OFF_COUNT, 32'h0);
    chk(q, 32'h0ff);
    $display("reset test done");
    bus(1'h1, wd_pkg::OFF_CTRL, 32'h1);
    bus(1'h1, wd_pkg::OFF_FRZ_SET, 32'h8);
    bus(1'h0, wd_pkg::OFF_CTRL, 32'h0);
    chk(q, 32'h1);
    nmi_seen <= 1'h0;
    bus(1'h1, wd_pkg::OFF_COUNT, 32'h3);
    n = 0;
    while (req !== 1'h1 && n < 100) begin @(posedge core_clk_in); n++; end
    chk({30'h0, req, nmi_seen}, 32'h2);
    while (rst !== 1'h0 && n < 200) begin @(posedge core_clk_in); n++; end
    repeat (2) @(posedge core_clk_in);
    bus(1'h0, wd_pkg::OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    $display("direct reset test done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// >>> tb/wd_monitor.sv
/*
  Port checker for the watchdog timer, bound to its top module.
  Assumes one clock domain and a synchronous active high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module wd_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic debug_halt_ctrl_in,
  input wire logic nmi_out,
  input wire logic wd_system_reset_req_out,
  input wire logic irq_out
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access");
  a_err_reads_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error response malformed");
  a_reset_req_sticky: assert property (
    wd_system_reset_req_out && !rst_in |=> wd_system_reset_req_out)
    else $error("reset request dropped");
  a_reset_clears_outs: assert property ($fell(rst_in) |->
    !nmi_out && !wd_system_reset_req_out && !irq_out) else $error("outputs set after reset");
  a_nmi_lead_time: assert property (
    $rose(nmi_out) |-> !wd_system_reset_req_out [*8]) else $error("reset too soon after nmi");
  a_halt_no_event: assert property (debug_halt_ctrl_in [*6] |=>
    !$rose(nmi_out) && !$rose(wd_system_reset_req_out)) else $error("event while halted");
endmodule // wd_monitor
bind watchdog_timer wd_monitor u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .debug_halt_ctrl_in(debug_halt_ctrl_in),
  .nmi_out(nmi_out), .wd_system_reset_req_out(wd_system_reset_req_out), .irq_out(irq_out));
`default_nettype wire

// >>> tb/wd_reset_ctrl.sv
/*
  System reset controller model: merges power-on and watchdog requests.
  Assumes the watchdog request stays high until reset is seen.
*/
`timescale 1ns/100ps
`default_nettype none
module wd_reset_ctrl (
  input wire logic por_in,
  input wire logic req_in,
  output logic rst_out
);
  assign rst_out = por_in | req_in;
endmodule // wd_reset_ctrl
`default_nettype wire
